// File: hdl/pmc_cpu_div.sv
// CPU clock divider that issues one enable tick per divided CPU clock period.
`timescale 1ns/100ps
module pmc_cpu_div (
    input wire logic core_clk,
    input wire logic rst,
    pmc_div_if.div dif
);
    logic [3:0] cnt;
    logic [3:0] term;

    // A selected sub clock runs undivided; otherwise the divide-by-8 bit overrides the code.
    assign term = dif.subSel ? pmc_pkg::TERM_1 :
                  dif.div8 ? pmc_pkg::TERM_8 :
                  (dif.divCode == pmc_pkg::DIV_CODE_1) ? pmc_pkg::TERM_1 :
                  (dif.divCode == pmc_pkg::DIV_CODE_2) ? pmc_pkg::TERM_2 :
                  (dif.divCode == pmc_pkg::DIV_CODE_4) ? pmc_pkg::TERM_4 : pmc_pkg::TERM_16;

    // The count freezes while the clock is gated, so a restart continues from the same count.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            dif.tick <= 1'b0;
        end else begin
            dif.tick <= dif.run && (cnt >= term);
            if (!dif.run) begin
                cnt <= cnt;
            end else if (cnt >= term) begin
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // pmc_cpu_div

// File: hdl/pmc_div_if.sv
// Interface between the power controller and its CPU clock divider.
`timescale 1ns/100ps
interface pmc_div_if;
    logic div8;
    logic [1:0] divCode;
    logic subSel;
    logic run;
    logic tick;
    modport ctrl (output div8, output divCode, output subSel, output run, input tick);
    modport div (input div8, input divCode, input subSel, input run, output tick);
endinterface

// File: hdl/pmc_pkg.sv
// Register map, field positions, reset values and state codes of the power mode controller.
package pmc_pkg;
    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_CLKCTL0 = 8'h00;
    localparam logic [7:0] OFS_CLKCTL1 = 8'h04;
    localparam logic [7:0] OFS_CLKCTL2 = 8'h08;
    localparam logic [7:0] OFS_PLLCTL = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CLKOUTCFG = 8'h18;

    // Clock control 0 fields.
    localparam int B_PERIPH_STOP_WAIT = 2;
    localparam int B_SUB_OSC_ON = 4;
    localparam int B_MAIN_CLK_STOP = 5;
    localparam int B_CPU_DIV8 = 6;
    localparam int B_SUB_CLK_CPU = 7;
    // Clock control 1 fields.
    localparam int B_STOP_ALL = 0;
    localparam int B_PLL_CPU_SRC = 1;
    localparam int B_MAIN_OSC_HIGH_DRIVE = 5;
    localparam int B_CPU_DIV_LOW = 6;
    localparam int B_CPU_DIV_HIGH = 7;
    // Clock control 2, PLL control and command fields.
    localparam int B_OSC_STOP_DET_EN = 0;
    localparam int B_RING_OSC_SRC = 1;
    localparam int B_PLL_ON = 7;
    localparam int B_WAIT_CMD = 0;

    // Values after reset.
    localparam logic RST_CPU_DIV8 = 1'b1;
    localparam logic RST_HIGH_DRIVE = 1'b1;
    localparam logic [1:0] RST_CLOCK_OUTPUT_PIN_SEL = 2'h0;

    // Clock output selections.
    localparam logic [1:0] CLOCK_OUTPUT_PIN_OFF = 2'h0;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_FC = 2'h1;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_F8 = 2'h2;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_F32 = 2'h3;

    // Divider codes and terminal counts for the CPU clock.
    localparam logic [1:0] DIV_CODE_1 = 2'h0;
    localparam logic [1:0] DIV_CODE_2 = 2'h1;
    localparam logic [1:0] DIV_CODE_4 = 2'h2;
    localparam logic [1:0] DIV_CODE_16 = 2'h3;
    localparam logic [3:0] TERM_1 = 4'h0;
    localparam logic [3:0] TERM_2 = 4'h1;
    localparam logic [3:0] TERM_4 = 4'h3;
    localparam logic [3:0] TERM_8 = 4'h7;
    localparam logic [3:0] TERM_16 = 4'hF;

    // Prescaler taps for the divided clock output.
    localparam int PRE_W = 5;
    localparam int F8_TAP = 2;
    localparam int F32_TAP = 4;

    // Operating mode codes shown in the status register.
    localparam logic [2:0] MODE_HIGH = 3'h0;
    localparam logic [2:0] MODE_LOW = 3'h1;
    localparam logic [2:0] MODE_LPD = 3'h2;
    localparam logic [2:0] MODE_PLL = 3'h3;
    localparam logic [2:0] MODE_RING = 3'h4;
    localparam logic [2:0] MODE_RINGLPD = 3'h5;

    // Power state of the core.
    typedef enum logic [2:0] {
        PMC_RUN = 3'b001,
        PMC_STOP = 3'b010,
        PMC_WAIT = 3'b100
    } pmc_pwr_e;
endpackage

// File: hdl/pmc_power_ctrl.sv
// Power mode controller: clock control bits, stop and wait sequencing and pin states.
// Notes on behaviour
// - Wait exit resumes with unchanged CPU clock.
// - Stop halts oscillators, CPU and peripheral clocks.
// - Listed external-clocked interrupts wake from stop.
// - Stop request forces divide-by-8 and high drive.
// - Wake restarts CPU clock, then service routine.
// - Same source after stop; main divided eight.
// - Bus pins hold or go high in stop.
// - Clock pin high for fc, else holds.
// - Stop exit sets divide-by-8 select bit.
// - Main stop in low-speed forces divide-by-8.
// - Divider and sub oscillator change freely.
// - Divider bits map to one, two, four, sixteen.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module pmc_power_ctrl #(
    parameter int IO_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic nmiReq,
    input wire logic keyIrq,
    input wire logic extPinIrq,
    input wire logic timerAEventIrq,
    input wire logic timerBEventIrq,
    input wire logic serialExtClkIrq,
    input wire logic voltageDownIrq,
    input wire logic periphIrq,
    input wire logic singleChipMode,
    input wire logic [19:0] addrIn,
    input wire logic [15:0] dataIn,
    input wire logic [3:0] chip_select_outputs_nIn,
    input wire logic byte_high_enable_out_nIn,
    input wire logic [IO_W-1:0] ioPortIn,
    input wire logic readStrobe_nIn,
    input wire logic writeStrobe_nIn,
    input wire logic write_strobe_low_byte_nIn,
    input wire logic write_strobe_high_byte_nIn,
    input wire logic hold_acknowledge_out_nIn,
    input wire logic busClkIn,
    input wire logic addrLatchEnIn,
    output logic [19:0] addrOut,
    output logic [15:0] dataOut,
    output logic [3:0] chip_select_outputs_n,
    output logic byte_high_enable_out_n,
    output logic [IO_W-1:0] ioPortOut,
    output logic readStrobe_n,
    output logic writeStrobe_n,
    output logic write_strobe_low_byte_n,
    output logic write_strobe_high_byte_n,
    output logic hold_acknowledge_out_n,
    output logic busClkOut,
    output logic addrLatchEn,
    output logic clock_output_pin,
    output logic cpuClkTick,
    output logic periphClkRun,
    output logic mainOscRun,
    output logic subOscRun,
    output logic ringOscRun,
    output logic pllRun,
    output logic mainOscHighDrive,
    output logic cpuResume
);
    // Power state and loose clock control bits.
    pmc_pkg::pmc_pwr_e pwr;
    pmc_pkg::pmc_pwr_e next_pwr;
    logic periphStopWait;
    logic sub_osc_on_bit;
    logic main_clock_stop_bit;
    logic cpu_div8_select;
    logic sub_clock_cpu_select;
    logic stop_all_clocks_bit;
    logic pll_cpu_source_select;
    logic main_osc_high_drive;
    logic cpu_divider_low_bit;
    logic cpu_divider_high_bit;
    logic osc_stop_detect_enable;
    logic ring_osc_source_select;
    logic pll_on_bit;
    logic [1:0] clkOutSel;
    logic fcToggle;
    logic [pmc_pkg::PRE_W-1:0] prescale;
    logic [8:0] pinSync;
    pmc_div_if dif ();

    // Synchronised wake sources and the chip mode strap.
    pmc_sync #(
        .WIDTH(9)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din({singleChipMode, periphIrq, voltageDownIrq, serialExtClkIrq, timerBEventIrq,
              timerAEventIrq, extPinIrq, keyIrq, nmiReq}),
        .dout(pinSync)
    );

    // CPU clock divider.
    pmc_cpu_div u_div (
        .core_clk(core_clk),
        .rst(rst),
        .dif(dif)
    );

    // Bus decode; a request is answered exactly once, one cycle after it appears.
    wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire pwrRun = (pwr == pmc_pkg::PMC_RUN);
    wire pwrStop = (pwr == pmc_pkg::PMC_STOP);
    wire pwrWait = (pwr == pmc_pkg::PMC_WAIT);
    wire wrEn = busReq & wb_we_i & wb_sel_i[0] & pwrRun;
    wire [7:0] wd = wb_dat_i[7:0];
    wire wrC0 = wrEn & (wb_adr_i == pmc_pkg::OFS_CLKCTL0);
    wire wrC1 = wrEn & (wb_adr_i == pmc_pkg::OFS_CLKCTL1);
    wire wrC2 = wrEn & (wb_adr_i == pmc_pkg::OFS_CLKCTL2);
    wire wrPll = wrEn & (wb_adr_i == pmc_pkg::OFS_PLLCTL);
    wire wrCmd = wrEn & (wb_adr_i == pmc_pkg::OFS_CMD);
    wire wrOut = wrEn & (wb_adr_i == pmc_pkg::OFS_CLKOUTCFG);

    // Operating mode decoded from the source select bits.
    wire modePll = pll_cpu_source_select & ~sub_clock_cpu_select & ~ring_osc_source_select;
    wire modeLow = sub_clock_cpu_select & ~main_clock_stop_bit;
    wire modeLpd = sub_clock_cpu_select & main_clock_stop_bit;
    wire modeRing = ~sub_clock_cpu_select & ring_osc_source_select;
    wire undivided = ~cpu_div8_select & ~cpu_divider_high_bit & ~cpu_divider_low_bit;
    wire modeHigh = ~sub_clock_cpu_select & ~ring_osc_source_select & ~pll_cpu_source_select;
    wire [2:0] modeCode = modeLpd ? pmc_pkg::MODE_LPD :
                          modeLow ? pmc_pkg::MODE_LOW :
                          (modeRing & main_clock_stop_bit) ? pmc_pkg::MODE_RINGLPD :
                          modeRing ? pmc_pkg::MODE_RING :
                          modePll ? pmc_pkg::MODE_PLL : pmc_pkg::MODE_HIGH;

    // Wake conditions; peripherals on internal clocks count only while they are clocked in wait.
    wire stopWake = |pinSync[6:0];
    wire waitWake = stopWake | (pinSync[7] & ~periphStopWait);
    wire stopEnter = wrC1 & wd[pmc_pkg::B_STOP_ALL] & ~modePll;
    wire waitEnter = wrCmd & wd[pmc_pkg::B_WAIT_CMD] & ~modePll;
    wire stopExit = pwrStop & stopWake;
    wire waitExit = pwrWait & waitWake;
    wire lpdEnter = wrC0 & modeLow & wd[pmc_pkg::B_MAIN_CLK_STOP];

    // Power state sequencing; a stop request is tested before a wait command, though they come from writes to different offsets.
    always_comb begin
        next_pwr = pwr;
        unique case (pwr)
            pmc_pkg::PMC_RUN: begin
                if (stopEnter) begin
                    next_pwr = pmc_pkg::PMC_STOP;
                end else if (waitEnter) begin
                    next_pwr = pmc_pkg::PMC_WAIT;
                end
            end
            pmc_pkg::PMC_STOP: begin
                if (stopWake) begin
                    next_pwr = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_WAIT: begin
                if (waitWake) begin
                    next_pwr = pmc_pkg::PMC_RUN;
                end
            end
            default: begin
                next_pwr = pmc_pkg::PMC_RUN;
            end
        endcase
    end

    // Next values of the control bits; writes that would leave PLL mode sideways are dropped.
    wire next_cpu_div8_select = (stopEnter | stopExit | lpdEnter) ? 1'b1 :
                                (wrC0 & ~modeLpd) ? wd[pmc_pkg::B_CPU_DIV8] : cpu_div8_select;
    wire next_sub_clock_cpu_select = (wrC0 & ~modePll) ? wd[pmc_pkg::B_SUB_CLK_CPU] :
                                     sub_clock_cpu_select;
    wire next_main_clock_stop_bit = (wrC0 & ~modePll) ? wd[pmc_pkg::B_MAIN_CLK_STOP] : main_clock_stop_bit;
    wire next_stop_all_clocks_bit = stopEnter ? 1'b1 : stopExit ? 1'b0 : stop_all_clocks_bit;
    wire next_main_osc_high_drive = stopEnter ? 1'b1 :
                                    wrC1 ? wd[pmc_pkg::B_MAIN_OSC_HIGH_DRIVE] : main_osc_high_drive;
    wire pllSetOk = modeHigh & undivided & pll_on_bit;
    wire next_pll_cpu_source_select = (wrC1 & (pllSetOk | ~wd[pmc_pkg::B_PLL_CPU_SRC])) ?
                                      wd[pmc_pkg::B_PLL_CPU_SRC] : pll_cpu_source_select;
    wire next_ring_osc_source_select = (wrC2 & ~modePll & ~sub_clock_cpu_select) ?
                                       wd[pmc_pkg::B_RING_OSC_SRC] : ring_osc_source_select;
    wire next_pll_on_bit = (wrPll & ~pll_cpu_source_select) ? wd[pmc_pkg::B_PLL_ON] : pll_on_bit;

    // State register and bits steered by the next-value logic.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr <= pmc_pkg::PMC_RUN;
            cpu_div8_select <= pmc_pkg::RST_CPU_DIV8;
            sub_clock_cpu_select <= 1'b0;
            main_clock_stop_bit <= 1'b0;
            stop_all_clocks_bit <= 1'b0;
            main_osc_high_drive <= pmc_pkg::RST_HIGH_DRIVE;
            pll_cpu_source_select <= 1'b0;
            ring_osc_source_select <= 1'b0;
            pll_on_bit <= 1'b0;
        end else begin
            pwr <= next_pwr;
            cpu_div8_select <= next_cpu_div8_select;
            sub_clock_cpu_select <= next_sub_clock_cpu_select;
            main_clock_stop_bit <= next_main_clock_stop_bit;
            stop_all_clocks_bit <= next_stop_all_clocks_bit;
            main_osc_high_drive <= next_main_osc_high_drive;
            pll_cpu_source_select <= next_pll_cpu_source_select;
            ring_osc_source_select <= next_ring_osc_source_select;
            pll_on_bit <= next_pll_on_bit;
        end
    end

    // Plain write-through bits; the divider and sub oscillator may change in any order.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periphStopWait <= 1'b0;
            sub_osc_on_bit <= 1'b0;
            cpu_divider_low_bit <= 1'b0;
            cpu_divider_high_bit <= 1'b0;
            osc_stop_detect_enable <= 1'b0;
            clkOutSel <= pmc_pkg::RST_CLOCK_OUTPUT_PIN_SEL;
        end else begin
            if (wrC0) begin
                periphStopWait <= wd[pmc_pkg::B_PERIPH_STOP_WAIT];
                sub_osc_on_bit <= wd[pmc_pkg::B_SUB_OSC_ON];
            end
            if (wrC1) begin
                cpu_divider_low_bit <= wd[pmc_pkg::B_CPU_DIV_LOW];
                cpu_divider_high_bit <= wd[pmc_pkg::B_CPU_DIV_HIGH];
            end
            if (wrC2) begin
                osc_stop_detect_enable <= wd[pmc_pkg::B_OSC_STOP_DET_EN];
            end
            if (wrOut) begin
                clkOutSel <= wd[1:0];
            end
        end
    end

    // Register read values; unmapped offsets read as zero and still get an answer.
    wire [7:0] rdC0 = {sub_clock_cpu_select, cpu_div8_select, main_clock_stop_bit, sub_osc_on_bit,
                       1'b0, periphStopWait, 2'h0};
    wire [7:0] rdC1 = {cpu_divider_high_bit, cpu_divider_low_bit, main_osc_high_drive, 3'h0,
                       pll_cpu_source_select, stop_all_clocks_bit};
    wire [7:0] rdC2 = {6'h00, ring_osc_source_select, osc_stop_detect_enable};
    wire [7:0] rdStat = {2'h0, pwr, modeCode};
    wire [7:0] rdData = (wb_adr_i == pmc_pkg::OFS_CLKCTL0) ? rdC0 :
                        (wb_adr_i == pmc_pkg::OFS_CLKCTL1) ? rdC1 :
                        (wb_adr_i == pmc_pkg::OFS_CLKCTL2) ? rdC2 :
                        (wb_adr_i == pmc_pkg::OFS_PLLCTL) ? {pll_on_bit, 7'h00} :
                        (wb_adr_i == pmc_pkg::OFS_STATUS) ? rdStat :
                        (wb_adr_i == pmc_pkg::OFS_CLKOUTCFG) ? {6'h00, clkOutSel} : 8'h00;

    // Wishbone answer: ack for one cycle, read data registered with it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? {24'h000000, rdData} : 32'h00000000;
        end
    end

    // Divider steering; the CPU clock runs only in the run state.
    assign dif.div8 = cpu_div8_select;
    assign dif.divCode = {cpu_divider_high_bit, cpu_divider_low_bit};
    assign dif.subSel = sub_clock_cpu_select;
    assign dif.run = pwrRun;

    // Clock gates and oscillator enables; stop turns every oscillator off.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpuClkTick <= 1'b0;
            periphClkRun <= 1'b1;
            mainOscRun <= 1'b1;
            subOscRun <= 1'b0;
            ringOscRun <= 1'b0;
            pllRun <= 1'b0;
            mainOscHighDrive <= pmc_pkg::RST_HIGH_DRIVE;
            cpuResume <= 1'b0;
        end else begin
            cpuClkTick <= dif.tick & pwrRun;
            periphClkRun <= pwrRun | (pwrWait & ~periphStopWait);
            mainOscRun <= ~pwrStop & ~main_clock_stop_bit;
            subOscRun <= ~pwrStop & sub_osc_on_bit;
            ringOscRun <= ~pwrStop & ring_osc_source_select;
            pllRun <= ~pwrStop & pll_on_bit;
            mainOscHighDrive <= main_osc_high_drive;
            cpuResume <= (stopExit | waitExit) & ~cpuResume;
        end
    end

    // Clock output sources: fc stops only in stop, the prescaled taps also in gated wait.
    wire preRun = pwrRun | (pwrWait & ~periphStopWait);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fcToggle <= 1'b0;
            prescale <= '0;
        end else begin
            fcToggle <= pwrStop ? fcToggle : ~fcToggle;
            prescale <= preRun ? prescale + 1'b1 : prescale;
        end
    end

    // Clock pin level; in expansion mode the pin mirrors the bus clock instead.
    wire clkPinNext = ~pinSync[8] ? busClkOut :
                      (clkOutSel == pmc_pkg::CLOCK_OUTPUT_PIN_FC) ? (pwrStop | fcToggle) :
                      (clkOutSel == pmc_pkg::CLOCK_OUTPUT_PIN_F8) ? prescale[pmc_pkg::F8_TAP] :
                      (clkOutSel == pmc_pkg::CLOCK_OUTPUT_PIN_F32) ? prescale[pmc_pkg::F32_TAP] : 1'b0;

    // Pin states; outside the run state values hold and strobes rest high.
    wire holdPins = ~pwrRun;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addrOut <= 20'h00000;
            dataOut <= 16'h0000;
            chip_select_outputs_n <= 4'hF;
            byte_high_enable_out_n <= 1'b1;
            ioPortOut <= '0;
            readStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            write_strobe_low_byte_n <= 1'b1;
            write_strobe_high_byte_n <= 1'b1;
            hold_acknowledge_out_n <= 1'b1;
            busClkOut <= 1'b1;
            addrLatchEn <= 1'b1;
            clock_output_pin <= 1'b0;
        end else begin
            if (!holdPins) begin
                addrOut <= addrIn;
                dataOut <= dataIn;
                chip_select_outputs_n <= chip_select_outputs_nIn;
                byte_high_enable_out_n <= byte_high_enable_out_nIn;
                ioPortOut <= ioPortIn;
            end
            readStrobe_n <= holdPins | readStrobe_nIn;
            writeStrobe_n <= holdPins | writeStrobe_nIn;
            write_strobe_low_byte_n <= holdPins | write_strobe_low_byte_nIn;
            write_strobe_high_byte_n <= holdPins | write_strobe_high_byte_nIn;
            hold_acknowledge_out_n <= holdPins | hold_acknowledge_out_nIn;
            busClkOut <= holdPins | busClkIn;
            addrLatchEn <= holdPins | addrLatchEnIn;
            clock_output_pin <= clkPinNext;
        end
    end
endmodule // pmc_power_ctrl

// File: hdl/pmc_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/100ps
module pmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // The first stage feeds only the second, so a metastable level never reaches logic.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end
endmodule // pmc_sync

// File: tb/pmc_power_ctrl_monitor.sv
// Concurrent checks on the bus handshake, stop-mode pins and wake-up of the power controller.
`timescale 1ns/100ps
module pmc_power_ctrl_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input logic wb_ack_o,
    input logic readStrobe_n,
    input logic addrLatchEn,
    input logic [19:0] addrOut,
    input logic cpuClkTick,
    input logic periphClkRun,
    input logic mainOscRun,
    input logic subOscRun,
    input logic ringOscRun,
    input logic pllRun,
    input logic mainOscHighDrive,
    input logic cpuResume
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // All oscillators off is read as stop; a main clock stop written with the sub oscillator off gives the same in run.
    wire stopNow = !mainOscRun && !subOscRun && !ringOscRun && !pllRun;
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
    property p_stop_pins; stopNow |-> readStrobe_n && addrLatchEn; endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("strobe low in stop");
    property p_stop_hold; stopNow && $past(stopNow) |-> $stable(addrOut); endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("address moved in stop");
    property p_stop_clk; stopNow |-> !cpuClkTick && !periphClkRun; endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop");
    property p_stop_drive; stopNow |-> mainOscHighDrive; endproperty
    a_stop_drive: assert property (p_stop_drive) else $error("drive not high in stop");
    property p_resume_pulse; cpuResume |=> !cpuResume; endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume too long");
    property p_resume_tick; cpuResume |-> ##[0:17] cpuClkTick; endproperty
    a_resume_tick: assert property (p_resume_tick) else $error("no tick after wake");
    c_stop: cover property (stopNow);
    c_resume: cover property (cpuResume);
    c_ack: cover property (wb_ack_o);
endmodule // pmc_power_ctrl_monitor

// File: tb/pmc_power_ctrl_test.sv
// Self-checking bench for the power controller: divider, stop wake sources and wait.
`timescale 1ns/100ps
module pmc_power_ctrl_test;
    logic core_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, singleChipMode = 1'b1;
    logic [7:0] wb_adr_i = 8'h00, wake = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, rnd = 32'h9E27A2D1, wb_dat_o;
    logic nmiReq, keyIrq, extPinIrq, timerAEventIrq, timerBEventIrq, serialExtClkIrq, voltageDownIrq, periphIrq;
    logic readStrobe_nIn, writeStrobe_nIn, write_strobe_low_byte_nIn, write_strobe_high_byte_nIn;
    logic hold_acknowledge_out_nIn, busClkIn, addrLatchEnIn, byte_high_enable_out_nIn, byte_high_enable_out_n;
    logic [19:0] addrIn, addrOut;
    logic [15:0] dataIn, dataOut;
    logic [7:0] ioPortIn, ioPortOut;
    logic [3:0] chip_select_outputs_nIn, chip_select_outputs_n;
    logic wb_ack_o, readStrobe_n, writeStrobe_n, write_strobe_low_byte_n, write_strobe_high_byte_n;
    logic hold_acknowledge_out_n, busClkOut, addrLatchEn, clock_output_pin, cpuClkTick, periphClkRun;
    logic mainOscRun, subOscRun, ringOscRun, pllRun, mainOscHighDrive, cpuResume;
    int badCount = 0, cmpCount = 0, cyc = 0;
    logic [7:0] q[$];
    assign {periphIrq, voltageDownIrq, serialExtClkIrq, timerBEventIrq, timerAEventIrq, extPinIrq, keyIrq, nmiReq} = wake;
    // Pin inputs follow the random word so held outputs in stop are tested against moving inputs.
    assign {readStrobe_nIn, writeStrobe_nIn, write_strobe_low_byte_nIn, write_strobe_high_byte_nIn} = rnd[3:0];
    assign {hold_acknowledge_out_nIn, busClkIn, addrLatchEnIn, byte_high_enable_out_nIn} = rnd[7:4];
    assign {addrIn, chip_select_outputs_nIn, ioPortIn} = rnd;
    assign dataIn = rnd[31:16];
    pmc_power_ctrl uut (.*);
    always #25 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random word moves at every rising edge; the cycle ceiling cuts a hang short.
    always @(posedge core_clk) begin
        rnd <= lfsr(rnd);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            badCount++;
            closeOut();
        end
    end
    task automatic closeOut();
        if (badCount == 0 && cmpCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkOut(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t output %0d expected %0d", $time, got, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled at a rising edge.
    task automatic wbx(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h0, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        wbx(a, 1'b0, 8'h00);
    endtask
    // Read data is compared with the oldest note while ack stands.
    always @(negedge core_clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0) chkReg(wb_dat_o, {24'h0, q.pop_front()});
    end
    // Cycles between two CPU ticks; the first wait aligns to a tick.
    task automatic gap(input int e);
        int n = 0;
        @(negedge core_clk);
        for (int k = 0; k < 40 && cpuClkTick !== 1'b1; k++) @(negedge core_clk);
        do begin
            @(negedge core_clk);
            n++;
        end while (cpuClkTick !== 1'b1 && n < 40);
        chkOut(n, e);
    endtask
    task automatic wakeBy(input int s);
        @(posedge core_clk);
        wake[s] <= 1'b1;
        for (int k = 0; k < 40 && cpuResume !== 1'b1; k++) @(negedge core_clk);
        chkOut(cpuResume, 1);
        @(posedge core_clk);
        wake[s] <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(pmc_pkg::OFS_CLKCTL0, 8'h40);
        rd(pmc_pkg::OFS_CLKCTL1, 8'h20);
        rd(8'hFC, 8'h00);
        wbx(pmc_pkg::OFS_CLKOUTCFG, 1'b1, 8'h01);
        wbx(pmc_pkg::OFS_CLKCTL0, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wbx(pmc_pkg::OFS_CLKCTL1, 1'b1, 8'(i << 6));
            gap(i == 3 ? 16 : 1 << i);
        end
        wbx(pmc_pkg::OFS_CLKCTL0, 1'b1, 8'h40);
        gap(8);
        for (int s = 0; s < 7; s++) begin
            wbx(pmc_pkg::OFS_CLKCTL0, 1'b1, 8'h00);
            wbx(pmc_pkg::OFS_CLKCTL1, 1'b1, 8'hC1);
            repeat (4) @(negedge core_clk);
            chkOut(mainOscRun, 0);
            chkOut(readStrobe_n & addrLatchEn, 1);
            chkOut(clock_output_pin, 1);
            wakeBy(s);
            rd(pmc_pkg::OFS_CLKCTL0, 8'h40);
            rd(pmc_pkg::OFS_CLKCTL1, 8'hE0);
            gap(8);
            repeat (6) @(posedge core_clk);
        end
        wbx(pmc_pkg::OFS_CLKCTL0, 1'b1, 8'h00);
        wbx(pmc_pkg::OFS_CLKCTL1, 1'b1, 8'h40);
        wbx(pmc_pkg::OFS_CMD, 1'b1, 8'h01);
        wakeBy(7);
        gap(2);
        closeOut();
    end
endmodule // pmc_power_ctrl_test
bind pmc_power_ctrl pmc_power_ctrl_monitor mon (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .readStrobe_n,
    .addrLatchEn, .addrOut, .cpuClkTick, .periphClkRun, .mainOscRun, .subOscRun, .ringOscRun, .pllRun,
    .mainOscHighDrive, .cpuResume);
